/* core/ditfd_decoder.v */
// Function
// - Code 29 on: no torque, speed mode.
// - Code 30 counts pulses, pulse terminal only.
// - Code 32 rising: immediate DC braking.
// - Code 33 active: fault 15, stop.
// - Code 34 on: ignore frequency changes.
// - Code 35 on: invert PID direction.
// - Code 36: panel stop, panel source only.
// - Code 37 rising, terminal source: go communication.
// - Code 38 on: freeze PID integral.
// - Code 39 on: preset replaces main source.
// - Code 40 on: preset replaces auxiliary source.
// - Code 43 selects PID gain set.
// - Codes 44/45: user faults 27/28, action.
// - Code 46 on: opposite control mode.
// - Code 47 rising: fastest stop, current limit.
// - Code 48: decel stop, time four, any source.
// - Code 49 rising: decelerate then DC braking.
// - Code 50 rising: clear run time if allowed.
// - Code 51 with two-line 1: three-line 1.
// - Mode codes 0..3: 2L1,2L2,3L1,3L2.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`include "ditfd_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module ditfd_decoder (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [9:0]  di_pin,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         torque_inhibit,
  output reg         speed_mode,
  output reg         dc_brake_now,
  output reg         fault_req,
  output reg  [7:0]  fault_code,
  output reg  [1:0]  user_fault_action,
  output reg         freq_change_lock,
  output reg         pid_direction,
  output reg         stop_req,
  output reg  [1:0]  stop_decel_sel,
  output reg  [1:0]  cmd_source,
  output reg         pid_integral_hold,
  output reg         main_use_preset,
  output reg         aux_use_preset,
  output reg         pid_gain_set_two,
  output reg         estop_req,
  output reg         decel_dc_brake_req,
  output reg         run_time_clear,
  output reg  [1:0]  eff_terminal_cmd_mode,
  output reg  [15:0] pulse_count
);

  // ------------------------------------------------------------
  // Input synchroniser and per-code terminal levels.
  // ------------------------------------------------------------
  reg [9:0]  sync1_q, sync2_q, prev_q;
  reg [5:0]  func_q [0:9];
  reg [31:0] cfg_q;
  integer    i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      prev_q  <= 10'h000;
    end else begin
      sync1_q <= di_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Level of any terminal set to a code; the pulse terminal is excluded
  // while it counts pulses, and reserved codes never match a use below.
  function any_on;
    input [5:0] code;
    input [9:0] lvl;
    integer k;
    begin
      any_on = 1'b0;
      for (k = 0; k < `DITFD_NUM_TERM; k = k + 1)
        if (func_q[k] == code && !(k == `DITFD_PULSE_TERM && func_q[k] == `DITFD_FC_PULSE))
          any_on = any_on | lvl[k];
    end
  endfunction

  wire torq_on   = any_on(`DITFD_FC_TORQ_INH, sync2_q);
  wire dcb_rise  = any_on(`DITFD_FC_DCB_NOW, sync2_q & ~prev_q);
  wire ext_on    = any_on(`DITFD_FC_EXT_FAULT, ~sync2_q);
  wire flock_on  = any_on(`DITFD_FC_FREQ_LOCK, sync2_q);
  wire prev_on   = any_on(`DITFD_FC_PID_REV, sync2_q);
  wire pstop_on  = any_on(`DITFD_FC_STOP_PANEL, sync2_q);
  wire comm_rise = any_on(`DITFD_FC_CMD_COMM, sync2_q & ~prev_q);
  wire ihold_on  = any_on(`DITFD_FC_PID_IHOLD, sync2_q);
  wire mpre_on   = any_on(`DITFD_FC_MAIN_PRE, sync2_q);
  wire apre_on   = any_on(`DITFD_FC_AUX_PRE, sync2_q);
  wire gain_on   = any_on(`DITFD_FC_PID_GAIN, sync2_q);
  wire uf1_on    = any_on(`DITFD_FC_UFAULT1, sync2_q);
  wire uf2_on    = any_on(`DITFD_FC_UFAULT2, sync2_q);
  wire tog_on    = any_on(`DITFD_FC_MODE_TOG, sync2_q);
  wire es_rise   = any_on(`DITFD_FC_ESTOP, sync2_q & ~prev_q);
  wire sany_on   = any_on(`DITFD_FC_STOP_ANY, sync2_q);
  wire ddcb_rise = any_on(`DITFD_FC_DEC_DCB, sync2_q & ~prev_q);
  wire rtc_rise  = any_on(`DITFD_FC_RT_CLEAR, sync2_q & ~prev_q);
  wire lsw_on    = any_on(`DITFD_FC_LINE_SW, sync2_q);
  wire pulse_en  = (func_q[`DITFD_PULSE_TERM] == `DITFD_FC_PULSE);

  // Config: [1:0] term cmd mode, [2] pid dir, [3] gain by terminal,
  // [4] ctrl mode torque, [6:5] user fault action, [7] run time A, [8] run time B,
  // [10:9] base command source.
  wire [1:0] tcm_cfg   = cfg_q[1:0];
  wire       pdir_cfg  = cfg_q[2];
  wire       gsel_cfg  = cfg_q[3];
  wire       torq_cfg  = cfg_q[4];
  wire       rt_ok     = cfg_q[7] & cfg_q[8];
  wire [1:0] src_cfg   = cfg_q[10:9];

  // ------------------------------------------------------------
  // Control outputs.
  // ------------------------------------------------------------
  reg        comm_latch_q;
  reg        dcb_q, es_q, ddcb_q;
  reg        ack_dcb, ack_es, ack_ddcb, ack_comm;
  wire [1:0] src_now = (comm_latch_q && src_cfg == `DITFD_SRC_TERM) ? `DITFD_SRC_COMM : src_cfg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      comm_latch_q <= 1'b0;
      dcb_q        <= 1'b0;
      es_q         <= 1'b0;
      ddcb_q       <= 1'b0;
      pulse_count  <= 16'h0000;
    end else begin
      if (comm_rise && src_cfg == `DITFD_SRC_TERM)
        comm_latch_q <= 1'b1;
      else if (ack_comm)
        comm_latch_q <= 1'b0;
      dcb_q  <= dcb_rise | (dcb_q & ~ack_dcb);
      es_q   <= es_rise | (es_q & ~ack_es);
      ddcb_q <= ddcb_rise | (ddcb_q & ~ack_ddcb);
      if (pulse_en && sync2_q[`DITFD_PULSE_TERM] && !prev_q[`DITFD_PULSE_TERM])
        pulse_count <= pulse_count + 16'h0001;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      torque_inhibit        <= 1'b0;
      speed_mode            <= 1'b1;
      dc_brake_now          <= 1'b0;
      fault_req             <= 1'b0;
      fault_code            <= 8'h00;
      user_fault_action     <= 2'h0;
      freq_change_lock      <= 1'b0;
      pid_direction         <= 1'b0;
      stop_req              <= 1'b0;
      stop_decel_sel        <= 2'h0;
      cmd_source            <= 2'h0;
      pid_integral_hold     <= 1'b0;
      main_use_preset       <= 1'b0;
      aux_use_preset        <= 1'b0;
      pid_gain_set_two      <= 1'b0;
      estop_req             <= 1'b0;
      decel_dc_brake_req    <= 1'b0;
      run_time_clear        <= 1'b0;
      eff_terminal_cmd_mode <= `DITFD_TCM_2LINE1;
    end else begin
      torque_inhibit    <= torq_on;
      speed_mode        <= torq_on | ~(torq_cfg ^ tog_on);
      dc_brake_now      <= dcb_q;
      freq_change_lock  <= flock_on;
      pid_direction     <= pdir_cfg ^ prev_on;
      pid_integral_hold <= ihold_on;
      main_use_preset   <= mpre_on;
      aux_use_preset    <= apre_on;
      pid_gain_set_two  <= gsel_cfg & gain_on;
      cmd_source        <= src_now;
      estop_req         <= es_q;
      decel_dc_brake_req <= ddcb_q;
      run_time_clear    <= rtc_rise & rt_ok;
      user_fault_action <= cfg_q[6:5];
      // External fault takes priority over user faults.
      if (ext_on) begin
        fault_req  <= 1'b1;
        fault_code <= `DITFD_FAULT_EXT;
      end else if (uf1_on) begin
        fault_req  <= 1'b1;
        fault_code <= `DITFD_FAULT_USER1;
      end else if (uf2_on) begin
        fault_req  <= 1'b1;
        fault_code <= `DITFD_FAULT_USER2;
      end else begin
        fault_req  <= 1'b0;
        fault_code <= 8'h00;
      end
      stop_req       <= ext_on | sany_on | (pstop_on && src_now == `DITFD_SRC_PANEL);
      stop_decel_sel <= sany_on ? `DITFD_DECEL_SEL4 : 2'h0;
      if (lsw_on && tcm_cfg == `DITFD_TCM_2LINE1)
        eff_terminal_cmd_mode <= `DITFD_TCM_3LINE1;
      else
        eff_terminal_cmd_mode <= tcm_cfg;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave.
  // ------------------------------------------------------------
  reg        aw_q, w_q;
  reg [11:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;
  wire       do_wr = aw_q & w_q & ~s_axi_bvalid;
  wire [3:0] widx  = awa_q[5:2];
  wire       wfunc = (awa_q <= `DITFD_REG_FUNC9);

  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Event register: bit0 dcb, bit1 estop, bit2 decel dcb, bit3 comm switch; write 1 acknowledges.
  always @* begin
    ack_dcb  = 1'b0;
    ack_es   = 1'b0;
    ack_ddcb = 1'b0;
    ack_comm = 1'b0;
    if (do_wr && awa_q == `DITFD_REG_EVENT && ws_q[0]) begin
      ack_dcb  = wd_q[0];
      ack_es   = wd_q[1];
      ack_ddcb = wd_q[2];
      ack_comm = wd_q[3];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awa_q        <= 12'h000;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DITFD_RESP_OKAY;
      cfg_q        <= `DITFD_CFG_RESET;
      for (i = 0; i < `DITFD_NUM_TERM; i = i + 1)
        func_q[i] <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DITFD_RESP_OKAY;
        if (wfunc) begin
          if (ws_q[0])
            func_q[widx] <= wd_q[5:0];
        end else if (awa_q == `DITFD_REG_CFG) begin
          if (ws_q[0])
            cfg_q[7:0] <= wd_q[7:0];
          if (ws_q[1])
            cfg_q[10:8] <= wd_q[10:8];
        end else if (awa_q != `DITFD_REG_EVENT)
          s_axi_bresp <= `DITFD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DITFD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `DITFD_RESP_OKAY;
      if (ra <= `DITFD_REG_FUNC9)
        s_axi_rdata <= {26'h0, func_q[ra[5:2]]};
      else if (ra == `DITFD_REG_CFG)
        s_axi_rdata <= {21'h0, cfg_q[10:0]};
      else if (ra == `DITFD_REG_STATUS)
        s_axi_rdata <= {6'h0, fault_code, 2'h0, eff_terminal_cmd_mode, cmd_source, stop_decel_sel,
                        stop_req, fault_req, pid_gain_set_two, aux_use_preset, main_use_preset,
                        pid_integral_hold, pid_direction, freq_change_lock, speed_mode, torque_inhibit};
      else if (ra == `DITFD_REG_EVENT)
        s_axi_rdata <= {28'h0, comm_latch_q, ddcb_q, es_q, dcb_q};
      else if (ra == `DITFD_REG_PULSES)
        s_axi_rdata <= {16'h0, pulse_count};
      else if (ra == `DITFD_REG_INPUTS)
        s_axi_rdata <= {22'h0, sync2_q};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `DITFD_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // ditfd_decoder
`default_nettype wire

/* core/ditfd_regs.vh */
`ifndef DITFD_REGS_VH
`define DITFD_REGS_VH
`define DITFD_NUM_TERM      10
`define DITFD_PULSE_TERM    4
`define DITFD_FC_TORQ_INH   6'h1d
`define DITFD_FC_PULSE      6'h1e
`define DITFD_FC_DCB_NOW    6'h20
`define DITFD_FC_EXT_FAULT  6'h21
`define DITFD_FC_FREQ_LOCK  6'h22
`define DITFD_FC_PID_REV    6'h23
`define DITFD_FC_STOP_PANEL 6'h24
`define DITFD_FC_CMD_COMM   6'h25
`define DITFD_FC_PID_IHOLD  6'h26
`define DITFD_FC_MAIN_PRE   6'h27
`define DITFD_FC_AUX_PRE    6'h28
`define DITFD_FC_PID_GAIN   6'h2b
`define DITFD_FC_UFAULT1    6'h2c
`define DITFD_FC_UFAULT2    6'h2d
`define DITFD_FC_MODE_TOG   6'h2e
`define DITFD_FC_ESTOP      6'h2f
`define DITFD_FC_STOP_ANY   6'h30
`define DITFD_FC_DEC_DCB    6'h31
`define DITFD_FC_RT_CLEAR   6'h32
`define DITFD_FC_LINE_SW    6'h33
`define DITFD_FAULT_EXT     8'h0f
`define DITFD_FAULT_USER1   8'h1b
`define DITFD_FAULT_USER2   8'h1c
`define DITFD_DECEL_SEL4    2'h3
`define DITFD_TCM_2LINE1    2'h0
`define DITFD_TCM_2LINE2    2'h1
`define DITFD_TCM_3LINE1    2'h2
`define DITFD_TCM_3LINE2    2'h3
`define DITFD_SRC_PANEL     2'h0
`define DITFD_SRC_TERM      2'h1
`define DITFD_SRC_COMM      2'h2
`define DITFD_REG_FUNC0     12'h000
`define DITFD_REG_FUNC9     12'h024
`define DITFD_REG_CFG       12'h040
`define DITFD_REG_CTRL      12'h044
`define DITFD_REG_STATUS    12'h048
`define DITFD_REG_EVENT     12'h04c
`define DITFD_REG_PULSES    12'h050
`define DITFD_REG_INPUTS    12'h054
`define DITFD_RESP_OKAY     2'h0
`define DITFD_RESP_SLVERR   2'h2
`define DITFD_CFG_RESET     32'h0000_0000
`endif

/* testbench/ditfd_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Checker on the decoder's ports
// ----------------------------------------
module ditfd_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_arready,
  input wire logic        torque_inhibit,
  input wire logic        speed_mode,
  input wire logic        fault_req,
  input wire logic [7:0]  fault_code,
  input wire logic        stop_req,
  input wire logic [1:0]  stop_decel_sel,
  input wire logic        run_time_clear,
  input wire logic [15:0] pulse_count
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_torque_speed: assert property (torque_inhibit |-> speed_mode)
    else $error("torque inhibit outside speed mode");
  chk_ext_stop: assert property (fault_code == 8'h0f |-> fault_req && stop_req)
    else $error("external fault without stop");
  chk_fault_code: assert property (fault_req |-> fault_code inside {8'h0f, 8'h1b, 8'h1c})
    else $error("fault raised with a bad number");
  chk_fault_idle: assert property (!fault_req |-> fault_code == 8'h00)
    else $error("fault number without fault");
  chk_decel_four: assert property (stop_decel_sel != 2'h0 |-> stop_req && stop_decel_sel == 2'h3)
    else $error("decel time four outside a stop");
  chk_clear_pulse: assert property (run_time_clear |=> !run_time_clear)
    else $error("run time clear longer than one cycle");
  chk_pulse_step: assert property (pulse_count != $past(pulse_count) |-> pulse_count == $past(pulse_count) + 16'h1)
    else $error("pulse count jumped");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during a read answer");
endmodule // ditfd_asserts
`default_nettype wire

/* testbench/ditfd_pins_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Terminal driver: levels plus pulse bursts
// ----------------------------------------
module ditfd_pins_model (
  input  wire logic       aclk,
  input  wire logic [9:0] level,
  input  wire logic [7:0] burst,
  input  wire logic       go,
  output wire logic [9:0] di_pin,
  output wire logic       busy
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q = 3'h0;
  wire        hi = ph_q[2] & busy;
  // Each pulse is four cycles high and four low, slow enough for the input synchroniser.
  always @(posedge aclk) begin
    if (go && !busy) begin
      left_q <= burst;
      ph_q <= 3'h0;
    end else if (busy) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) left_q <= left_q - 8'h01;
    end
  end
  assign busy = left_q != 8'h00;
  assign di_pin = level ^ {5'h00, hi, 3'h0, hi};
endmodule // ditfd_pins_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ditfd_regs.vh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
  logic        aclk, aresetn, go, busy, torque_inhibit, speed_mode, dc_brake_now, fault_req, freq_change_lock;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pid_direction, stop_req;
  logic        pid_integral_hold, main_use_preset, aux_use_preset, pid_gain_set_two, estop_req;
  logic        decel_dc_brake_req, run_time_clear;
  logic [1:0]  s_axi_bresp, s_axi_rresp, user_fault_action, stop_decel_sel, cmd_source, eff_terminal_cmd_mode;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  fault_code, burst;
  logic [9:0]  lvl, di_pin;
  logic [15:0] pulse_count;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [33:0] exp_q[$];
  int          error_cnt, compares, rtc_cnt, i, t, n;
  wire  [17:0] obs = {torque_inhibit, dc_brake_now, freq_change_lock, pid_direction, pid_integral_hold,
                      main_use_preset, aux_use_preset, estop_req, decel_dc_brake_req, stop_req, stop_decel_sel,
                      cmd_source, pid_gain_set_two, speed_mode, eff_terminal_cmd_mode};
  logic [5:0]  tc [28] = '{6'h1d, 6'h1d, 6'h20, 6'h22, 6'h23, 6'h23, 6'h26, 6'h27, 6'h28, 6'h2f, 6'h31, 6'h1f,
                           6'h29, 6'h2a, 6'h1e, 6'h24, 6'h24, 6'h30, 6'h25, 6'h2b, 6'h2b, 6'h2e, 6'h2e, 6'h33,
                           6'h33, 6'h33, 6'h32, 6'h32};
  logic [11:0] tg [28] = '{12'h0, 12'h10, 12'h0, 12'h0, 12'h0, 12'h4, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0,
                           12'h0, 12'h0, 12'h0, 12'h0, 12'h200, 12'h400, 12'h200, 12'h8, 12'h0, 12'h0, 12'h10,
                           12'h0, 12'h1, 12'h3, 12'h180, 12'h80};
  logic [17:0] te [28] = '{18'h20004, 18'h20004, 18'h10004, 18'h08004, 18'h04004, 18'h00004, 18'h02004, 18'h01004,
                           18'h00804, 18'h00404, 18'h00204, 18'h4, 18'h4, 18'h4, 18'h4, 18'h104, 18'h14, 18'h1e4,
                           18'h24, 18'hc, 18'h4, 18'h0, 18'h4, 18'h6, 18'h5, 18'h7, 18'h4, 18'h4};
  logic [5:0]  fc [4] = '{6'h2c, 6'h2c, 6'h2d, 6'h2d};
  logic [9:0]  fl [4] = '{10'h003, 10'h001, 10'h003, 10'h002};
  logic [11:0] fe [4] = '{12'h8dc, 12'h87d, 12'h8e4, 12'h004};

  ditfd_decoder u_ditfd_decoder (.aclk, .aresetn, .di_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .torque_inhibit, .speed_mode, .dc_brake_now, .fault_req, .fault_code, .user_fault_action, .freq_change_lock,
    .pid_direction, .stop_req, .stop_decel_sel, .cmd_source, .pid_integral_hold, .main_use_preset,
    .aux_use_preset, .pid_gain_set_two, .estop_req, .decel_dc_brake_req, .run_time_clear,
    .eff_terminal_cmd_mode, .pulse_count);
  ditfd_pins_model u_ditfd_pins_model (.aclk, .level(lvl), .burst, .go, .di_pin, .busy);

  always #50 aclk = ~aclk;

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic to_fail;
    error_cnt++;
    stop_test();
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask

  // One AXI4-Lite transfer; a read leaves its expected answer in the queue.
  task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r = `DITFD_RESP_OKAY);
    logic       ta, tw, tb;
    logic [1:0] rs;
    int         k;
    tb = 1'b0;
    if (rd) exp_q.push_back({r, d});
    if (rd) s_axi_araddr <= {20'h0, a};
    else s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    {s_axi_arvalid, s_axi_rready, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {rd, rd, !rd, !rd, !rd};
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge aclk);
      ta = (s_axi_arvalid & s_axi_arready) | (s_axi_awvalid & s_axi_awready);
      tw = s_axi_wvalid & s_axi_wready;
      tb = rd ? s_axi_rvalid : s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) {s_axi_arvalid, s_axi_awvalid} <= 2'b00;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    {s_axi_rready, s_axi_bready} <= 2'b00;
    // Let one edge pass so that the next call does not reassign the ready lines in this time step.
    @(posedge aclk);
    if (!tb) to_fail();
    if (!rd) chk("bresp", r, rs);
  endtask

  always @(posedge aclk) begin
    if (run_time_clear === 1'b1) rtc_cnt <= rtc_cnt + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
  end

  initial begin
    {aclk, aresetn, go, lvl, burst, error_cnt, compares, rtc_cnt} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = {2'b00, 4'hf};
    t = $urandom(44063);
    tick(10);
    aresetn <= 1'b1;
    tick(1);
    chk("idle", 18'h00004, obs);
    bus(1, `DITFD_REG_CFG, `DITFD_CFG_RESET);
    bus(1, `DITFD_REG_FUNC9, 32'h0);
    bus(1, `DITFD_REG_CTRL, 32'h0, `DITFD_RESP_SLVERR);
    bus(0, `DITFD_REG_CTRL, 32'h1, `DITFD_RESP_SLVERR);
    $display("test reset done");
    for (i = 0; i < 28; i++) begin
      t = $urandom_range(9, 5);
      bus(0, `DITFD_REG_CFG, tg[i]);
      bus(0, 12'(4 * t), tc[i]);
      rtc_cnt <= 0;
      lvl <= 10'(1 << t);
      tick(5);
      chk("levels", te[i], obs);
      chk("clears", tc[i] == 6'h32 && tg[i][8:7] == 2'b11, rtc_cnt);
      lvl <= '0;
      bus(0, `DITFD_REG_EVENT, 32'hf);
      tick(5);
      chk("idle", {3'h0, tg[i][2], 8'h00, tg[i][10:9], 1'b0, !tg[i][4], tg[i][1:0]}, obs);
      bus(0, 12'(4 * t), 32'h0);
    end
    $display("test codes done");
    lvl <= 10'h002;
    tick(5);
    bus(0, 12'h004, `DITFD_FC_EXT_FAULT);
    bus(0, `DITFD_REG_CFG, 32'h40);
    for (i = 0; i < 4; i++) begin
      bus(0, `DITFD_REG_FUNC0, fc[i]);
      lvl <= fl[i];
      tick(5);
      chk("faults", fe[i], {fault_req, fault_code, user_fault_action, stop_req});
    end
    bus(0, 12'h004, 32'h0);
    $display("test faults done");
    n = $urandom_range(20, 3);
    bus(0, 12'h010, `DITFD_FC_PULSE);
    bus(0, `DITFD_REG_FUNC0, `DITFD_FC_PULSE);
    burst <= 8'(n);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
    for (i = 0; i < 1000 && busy; i++) @(posedge aclk);
    if (busy) to_fail();
    tick(5);
    chk("pulse_count", n, pulse_count);
    bus(1, `DITFD_REG_PULSES, n);
    bus(1, 12'h010, `DITFD_FC_PULSE);
    bus(1, `DITFD_REG_INPUTS, 32'h2);
    $display("test pulses done");
    stop_test();
  end
endmodule // tb_top

bind ditfd_decoder ditfd_asserts u_ditfd_asserts (.aclk, .aresetn, .s_axi_rvalid, .s_axi_arready,
  .torque_inhibit, .speed_mode, .fault_req, .fault_code, .stop_req, .stop_decel_sel, .run_time_clear,
  .pulse_count);
`default_nettype wire
